/* logic/sbc_lowpower_restart_failsafe_fsm.sv */
/*
 * sleep, restart and fail-safe mode controller of a system basis chip.
 * assumes analog monitors and the watchdog deliver one-cycle event pulses
 * or levels from outside this clock domain; all are synchronised here.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sbc_mode_cfg.svh"
module sbc_lowpower_restart_failsafe_fsm (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] modeRequest,
    input wire logic modeRequestStrobe,
    input wire logic initAfterRelease,
    input wire logic mainUv,
    input wire logic mainOv,
    input wire logic mainShort,
    input wire logic thermalHot,
    input wire logic watchdogFail,
    input wire logic watchdogFailCountCfg,
    input wire logic ovResetSelect,
    input wire logic pullupConfig,
    input wire logic measureSelect,
    input wire sbc_mode_pkg::wake_t wakeEnable,
    input wire sbc_mode_pkg::wake_t wakeEvent,
    input wire logic wakeStatusClear,
    input wire sbc_mode_pkg::can_mode_t canModeSel,
    input wire logic auxSupplySel,
    input wire logic gpioSwitchSel,
    input wire logic statusClear,
    output logic mainSupplyOn,
    output logic auxSupplyOn,
    output logic reset_out_n,
    output logic watchdogRun,
    output logic watchdogLongWindow,
    output logic [2:0] watchdogPeriod,
    output logic spiEnable,
    output logic gpioSwitchOn,
    output logic cyclicEnable,
    output sbc_mode_pkg::can_mode_t canMode,
    output logic failOutput,
    output sbc_mode_pkg::wake_t wakeSourceActive,
    output sbc_mode_pkg::wake_t wakeStatus,
    output logic [1:0] deviceStatus,
    output logic [1:0] watchdogFailCount,
    output logic mainUvFlag,
    output logic mainOvFlag,
    output logic mainShortFlag,
    output logic thermalFlag,
    output logic failFlag,
    output logic cmdFailFlag,
    output sbc_mode_pkg::mode_e mode
);
    import sbc_mode_pkg::*;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int SW = 7 + `WAKE_W;
    logic [SW-1:0] syncA;
    logic [SW-1:0] syncB;
    logic [SW-1:0] syncC;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
        end else begin
            syncA <= {mainUv, mainOv, mainShort, thermalHot, watchdogFail,
                      ovResetSelect, pullupConfig, wakeEvent};
            syncB <= syncA;
            syncC <= syncB;
        end
    end
    logic uvS, ovS, scS, hotS, wdS, ovSelS, pullS;
    wake_t wakeS, wakeRise;
    assign {uvS, ovS, scS, hotS, wdS, ovSelS, pullS, wakeS} = syncB;
    logic uvEv, ovEv, scEv, wdEv;
    assign uvEv = uvS & ~syncC[SW-1];
    assign ovEv = ovS & ~syncC[SW-2];
    assign scEv = scS & ~syncC[SW-3];
    assign wdEv = wdS & ~syncC[SW-5];
    assign wakeRise = wakeS & ~syncC[`WAKE_W-1:0];
    // ************************************************************
    // event decode
    // ************************************************************
    wake_t allowed;
    assign allowed = measureSelect ? (wakeEnable & ~(`WAKE_W'(1) << `WAKE_SENSE)
                     & ~(`WAKE_W'(1) << `WAKE_PIN)) : wakeEnable;
    logic secondFail, active, ovAct;
    assign secondFail = (watchdogFailCount != `STAT_NONE);
    assign active = (mode == MODE_NORMAL) || (mode == MODE_STOP) || (mode == MODE_INIT);
    assign ovAct = ovEv & ovSelS & active;
    logic wdToFs, wdToRs;
    // cfg 2 (cfg bit 1, no pull-up): first; cfg 4 (cfg bit 0, no pull-up): second
    assign wdToFs = wdEv && active && !pullS && (watchdogFailCountCfg || secondFail);
    assign wdToRs = wdEv && active && !wdToFs;
    logic fsEnter, uvRestart, rsEnter;
    assign fsEnter = active && (hotS || scEv || (ovAct && !pullS) || wdToFs);
    assign uvRestart = uvEv && ((mode == MODE_NORMAL) || (mode == MODE_STOP)
                       || (mode == MODE_INIT && initAfterRelease));
    assign rsEnter = active && (uvRestart || (ovAct && pullS) || wdToRs);
    logic sleepReq, badSleep;
    assign sleepReq = modeRequestStrobe && (modeRequest == `REQ_SLEEP)
                      && (mode == MODE_NORMAL || mode == MODE_STOP);
    assign badSleep = (allowed == '0) || (mode == MODE_STOP);
    // ************************************************************
    // timer on the internal clock
    // ************************************************************
    logic [`TIMER_W-1:0] timer, next_timer;
    logic fsDone, rdDone, tsdDone;
    assign fsDone = (timer >= `TIMER_W'(`FS_FILTER_CYC - 1));
    assign rdDone = (timer >= `TIMER_W'(`RESET_DELAY_CYC - 1));
    assign tsdDone = (timer >= `TIMER_W'(`TSD_DELAY_CYC - 1));
    logic tsdPending, wakeStored, fsEntry;
    // ************************************************************
    // mode state machine
    // ************************************************************
    mode_e next_mode;
    always_comb begin
        next_mode = mode;
        unique case (mode)
            MODE_INIT, MODE_NORMAL, MODE_STOP: begin
                if (fsEnter) begin
                    next_mode = MODE_FAILSAFE;
                end else if (rsEnter) begin
                    next_mode = MODE_RESTART;
                end else if (sleepReq) begin
                    next_mode = badSleep ? MODE_RESTART : MODE_SLEEP;
                end else if (mode == MODE_INIT && modeRequestStrobe) begin
                    next_mode = MODE_NORMAL;
                end else if (modeRequestStrobe && modeRequest == `REQ_STOP) begin
                    next_mode = MODE_STOP;
                end else if (modeRequestStrobe && modeRequest == `REQ_NORMAL) begin
                    next_mode = MODE_NORMAL;
                end
            end
            MODE_SLEEP: begin
                if (hotS || scEv) begin
                    next_mode = MODE_FAILSAFE;
                end else if ((wakeRise & allowed) != '0 || wakeStatus != '0) begin
                    next_mode = MODE_RESTART;
                end
            end
            MODE_RESTART: begin
                if (rdDone) begin
                    next_mode = MODE_NORMAL;
                end
            end
            MODE_FAILSAFE: begin
                if (tsdPending) begin
                    if (!hotS && tsdDone) begin
                        next_mode = MODE_RESTART;
                    end
                end else if (fsDone && (wakeStored || (wakeRise & wakeSourceActive) != '0)) begin
                    next_mode = MODE_RESTART;
                end
            end
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode <= MODE_INIT;
        end else begin
            mode <= next_mode;
        end
    end
    assign fsEntry = (next_mode == MODE_FAILSAFE) && (mode != MODE_FAILSAFE);

    // one timebase, restarted on every mode change and, in fail-safe after a thermal entry, while hot
    always_comb begin
        next_timer = timer + `TIMER_W'(1);
        if (next_mode != mode || (mode == MODE_FAILSAFE && tsdPending && hotS)) begin
            next_timer = '0;
        end else if (timer == '1) begin
            next_timer = timer;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timer <= '0;
        end else begin
            timer <= next_timer;
        end
    end

    // ************************************************************
    // fail-safe bookkeeping
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tsdPending <= 1'b0;
            wakeStored <= 1'b0;
        end else if (fsEntry) begin
            tsdPending <= hotS;
            wakeStored <= 1'b0;
        end else if (mode == MODE_FAILSAFE && (wakeRise & wakeSourceActive) != '0) begin
            wakeStored <= 1'b1;
        end
    end

    // ************************************************************
    // wake status
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wakeStatus <= '0;
        end else if (fsEntry) begin
            wakeStatus <= '0;
        end else begin
            wakeStatus <= (wakeStatusClear ? '0 : wakeStatus) | (wakeRise & allowed);
        end
    end

    // ************************************************************
    // status fields
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            deviceStatus <= `STAT_NONE;
            watchdogFailCount <= `STAT_NONE;
            mainUvFlag <= 1'b0;
            mainOvFlag <= 1'b0;
            mainShortFlag <= 1'b0;
            thermalFlag <= 1'b0;
            failFlag <= 1'b0;
            cmdFailFlag <= 1'b0;
        end else begin
            if (next_mode == MODE_SLEEP && mode != MODE_SLEEP) begin
                deviceStatus <= `STAT_SLEEP;
            end else if (mode == MODE_SLEEP && next_mode == MODE_RESTART) begin
                deviceStatus <= `STAT_SLEEP;
            end else if (fsEntry || rsEnter) begin
                deviceStatus <= `STAT_FAIL;
            end else if (statusClear) begin
                deviceStatus <= `STAT_NONE;
            end
            if (wdEv && active) begin
                watchdogFailCount <= secondFail ? `FAILCNT_TWO : `FAILCNT_ONE;
            end else if (statusClear) begin
                watchdogFailCount <= `STAT_NONE;
            end
            mainUvFlag <= (uvEv | scEv) | (mainUvFlag & ~statusClear);
            mainOvFlag <= ovEv | (mainOvFlag & ~statusClear);
            mainShortFlag <= scEv | (mainShortFlag & ~statusClear);
            thermalFlag <= (hotS & fsEntry) | (thermalFlag & ~statusClear);
            failFlag <= (fsEntry | failFlag) & ~(statusClear & ~fsEntry);
            cmdFailFlag <= (sleepReq & badSleep) | (cmdFailFlag & ~statusClear);
        end
    end

    // ************************************************************
    // fail output, cleared by status clear only in init, normal or stop
    // ************************************************************
    logic foSet;
    assign foSet = fsEntry || ovAct || (wdEv && active
                   && (watchdogFailCountCfg || secondFail));
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            failOutput <= 1'b0;
        end else if (foSet) begin
            failOutput <= 1'b1;
        end else if (statusClear && active) begin
            failOutput <= 1'b0;
        end
    end

    // ************************************************************
    // supplies, transceiver and pins per mode
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mainSupplyOn <= 1'b1;
            auxSupplyOn <= 1'b0;
            reset_out_n <= 1'b0;
            watchdogRun <= 1'b0;
            spiEnable <= 1'b1;
            gpioSwitchOn <= 1'b0;
            cyclicEnable <= 1'b0;
            canMode <= `CAN_OFF;
            wakeSourceActive <= '0;
        end else begin
            unique case (next_mode)
                MODE_INIT, MODE_NORMAL, MODE_STOP: begin
                    mainSupplyOn <= 1'b1;
                    auxSupplyOn <= auxSupplySel;
                    reset_out_n <= 1'b1;
                    watchdogRun <= 1'b1;
                    spiEnable <= 1'b1;
                    gpioSwitchOn <= gpioSwitchSel;
                    cyclicEnable <= allowed[`WAKE_TIMER];
                    canMode <= canModeSel;
                    wakeSourceActive <= allowed;
                end
                MODE_SLEEP: begin
                    mainSupplyOn <= 1'b0;
                    reset_out_n <= 1'b0;
                    watchdogRun <= 1'b0;
                    spiEnable <= 1'b0;
                    canMode <= (canModeSel == `CAN_OFF) ? `CAN_OFF : `CAN_WAKE;
                end
                MODE_RESTART: begin
                    mainSupplyOn <= 1'b1;
                    auxSupplyOn <= 1'b0;
                    reset_out_n <= 1'b0;
                    watchdogRun <= 1'b0;
                    spiEnable <= 1'b0;
                    gpioSwitchOn <= 1'b0;
                    canMode <= (canMode == `CAN_OFF) ? `CAN_OFF : `CAN_WAKE;
                end
                MODE_FAILSAFE: begin
                    mainSupplyOn <= 1'b0;
                    auxSupplyOn <= 1'b0;
                    reset_out_n <= 1'b0;
                    watchdogRun <= 1'b0;
                    spiEnable <= 1'b0;
                    gpioSwitchOn <= 1'b0;
                    cyclicEnable <= 1'b0;
                    canMode <= `CAN_WAKE;
                    wakeSourceActive <= measureSelect ? (`WAKE_W'(1) << `WAKE_BUS)
                        : ((`WAKE_W'(1) << `WAKE_BUS) | (`WAKE_W'(1) << `WAKE_SENSE)
                        | (wakeEnable & (`WAKE_W'(1) << `WAKE_PIN)));
                end
            endcase
        end
    end

    // ************************************************************
    // watchdog restart after reset release
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            watchdogLongWindow <= 1'b1;
            watchdogPeriod <= `WD_PERIOD_DEFAULT;
        end else if (mode == MODE_RESTART && next_mode == MODE_NORMAL) begin
            watchdogLongWindow <= 1'b1;
            watchdogPeriod <= `WD_PERIOD_DEFAULT;
        end else if (wdEv == 1'b0 && modeRequestStrobe && mode == MODE_NORMAL) begin
            watchdogLongWindow <= 1'b0;
        end
    end
endmodule : sbc_lowpower_restart_failsafe_fsm

`default_nettype wire

/* logic/sbc_mode_cfg.svh */
/*
 * constants of the low-power / restart / fail-safe mode controller.
 * assumes a 20 MHz reference clock; included by the package and the design file.
 */
`ifndef SBC_MODE_CFG_SVH
`define SBC_MODE_CFG_SVH

`define CLK_PERIOD_NS 50
`define RESET_DELAY_US 10
`define RESET_DELAY_CYC ((`RESET_DELAY_US * 1000) / `CLK_PERIOD_NS)
`define FS_FILTER_MS 100
`define FS_FILTER_CYC ((`FS_FILTER_MS * 1000000) / `CLK_PERIOD_NS)
`define TSD_DELAY_MS 1000
`define TSD_DELAY_CYC ((`TSD_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define TIMER_W 25
`define WD_PERIOD_DEFAULT 3'h4
`define STAT_NONE 2'h0
`define STAT_FAIL 2'h1
`define STAT_SLEEP 2'h2
`define FAILCNT_ONE 2'h1
`define FAILCNT_TWO 2'h2
`define CAN_OFF 2'h0
`define CAN_WAKE 2'h1
`define CAN_RXONLY 2'h2
`define CAN_ON 2'h3
`define REQ_NONE 2'h0
`define REQ_SLEEP 2'h1
`define REQ_STOP 2'h2
`define REQ_NORMAL 2'h3
`define WAKE_W 4
`define WAKE_BUS 0
`define WAKE_SENSE 1
`define WAKE_PIN 2
`define WAKE_TIMER 3

`endif

/* logic/sbc_mode_pkg.sv */
/*
 * types of the mode controller.
 * assumes sbc_mode_cfg.svh is on the include path.
 */
`include "sbc_mode_cfg.svh"

package sbc_mode_pkg;
    typedef enum logic [5:0] {
        MODE_INIT = 6'h01,
        MODE_NORMAL = 6'h02,
        MODE_STOP = 6'h04,
        MODE_SLEEP = 6'h08,
        MODE_RESTART = 6'h10,
        MODE_FAILSAFE = 6'h20
    } mode_e;
    typedef logic [1:0] can_mode_t;
    typedef logic [`WAKE_W-1:0] wake_t;
endpackage : sbc_mode_pkg

/* tb/sbc_mode_chk.sv */
/* port checker of the sleep, restart and fail-safe mode controller.
   assumes it is bound to the controller and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
`include "sbc_mode_cfg.svh"
module sbc_mode_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] modeRequest,
    input wire logic modeRequestStrobe,
    input wire logic measureSelect,
    input wire logic mainSupplyOn,
    input wire logic auxSupplyOn,
    input wire logic reset_out_n,
    input wire logic watchdogRun,
    input wire logic watchdogLongWindow,
    input wire logic [2:0] watchdogPeriod,
    input wire logic spiEnable,
    input wire logic gpioSwitchOn,
    input wire logic cyclicEnable,
    input wire sbc_mode_pkg::can_mode_t canMode,
    input wire logic failOutput,
    input wire sbc_mode_pkg::wake_t wakeSourceActive,
    input wire logic [1:0] deviceStatus,
    input wire logic failFlag,
    input wire logic cmdFailFlag,
    input wire sbc_mode_pkg::mode_e mode
);
    import sbc_mode_pkg::*;
    localparam int rdLast = `RESET_DELAY_CYC - 1;
    // ****************
    // assertions
    // ****************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_sleep_outputs_off: assert property (
        mode == MODE_SLEEP |-> !mainSupplyOn && !reset_out_n && !watchdogRun && !spiEnable)
        else $error("sleep outputs not off");
    a_sleep_status_set: assert property (
        $rose(mode == MODE_SLEEP) |-> deviceStatus == `STAT_SLEEP)
        else $error("sleep entry not recorded");
    a_restart_reset_low: assert property (
        mode == MODE_RESTART |-> !reset_out_n && !auxSupplyOn && !gpioSwitchOn)
        else $error("restart outputs wrong");
    a_restart_exit_bound: assert property (
        $rose(mode == MODE_RESTART) |-> ##[rdLast:rdLast] (mode == MODE_RESTART)
            ##1 (mode == MODE_NORMAL && reset_out_n))
        else $error("restart exit late or early");
    a_rise_window_reload: assert property (
        $rose(reset_out_n) |-> watchdogLongWindow && watchdogPeriod == `WD_PERIOD_DEFAULT)
        else $error("watchdog not reloaded on reset release");
    a_failsafe_outputs_safe: assert property (
        mode == MODE_FAILSAFE |-> !mainSupplyOn && !auxSupplyOn && !gpioSwitchOn
            && !cyclicEnable && canMode == `CAN_WAKE && failOutput)
        else $error("fail-safe outputs wrong");
    a_failsafe_flag_set: assert property (
        $rose(mode == MODE_FAILSAFE) |-> failFlag && deviceStatus == `STAT_FAIL)
        else $error("fail-safe status wrong");
    a_measure_no_pins: assert property (
        (mode == MODE_SLEEP || mode == MODE_FAILSAFE) && measureSelect
            |-> !wakeSourceActive[`WAKE_SENSE] && !wakeSourceActive[`WAKE_PIN])
        else $error("measure pins act as wake sources");
    a_restart_keeps_fail: assert property (
        $past(failOutput) && $past(mode) == MODE_RESTART |-> failOutput)
        else $error("fail output dropped after restart");
    a_stop_sleep_refused: assert property (
        $past(modeRequestStrobe) && $past(modeRequest) == `REQ_SLEEP && $past(mode) == MODE_STOP
            |-> mode == MODE_RESTART && cmdFailFlag)
        else $error("stop to sleep not refused");
    c_sleep: cover property (mode == MODE_SLEEP);
    c_restart: cover property ($rose(mode == MODE_RESTART));
    c_failsafe: cover property ($rose(mode == MODE_FAILSAFE));
endmodule : sbc_mode_chk
bind sbc_lowpower_restart_failsafe_fsm sbc_mode_chk sbc_mode_chk_inst (.ref_clk, .rst,
    .modeRequest, .modeRequestStrobe, .measureSelect, .mainSupplyOn, .auxSupplyOn,
    .reset_out_n, .watchdogRun, .watchdogLongWindow, .watchdogPeriod, .spiEnable,
    .gpioSwitchOn, .cyclicEnable, .canMode, .failOutput, .wakeSourceActive, .deviceStatus,
    .failFlag, .cmdFailFlag, .mode);
`default_nettype wire

/* tb/mcu_model.sv */
/* microcontroller model that issues mode requests.
   assumes the bench calls request at any time; ignored while held in reset. */
`timescale 1ns/100ps
`default_nettype none
`include "sbc_mode_cfg.svh"
module mcu_model (
    input wire logic ref_clk,
    input wire logic reset_out_n,
    output logic [1:0] modeRequest,
    output logic modeRequestStrobe,
    output logic wakeStatusClear
);
    // ****************
    // request driver
    // ****************
    initial begin
        modeRequest = `REQ_NONE;
        modeRequestStrobe = 1'b0;
        wakeStatusClear = 1'b0;
    end
    task automatic request(input logic [1:0] code, input logic skipClear);
        @(negedge ref_clk);
        if (reset_out_n !== 1'b1) begin
            return;
        end
        if (code == `REQ_SLEEP && !skipClear) begin
            wakeStatusClear = 1'b1;
            @(negedge ref_clk);
            wakeStatusClear = 1'b0;
        end
        modeRequest = code;
        modeRequestStrobe = 1'b1;
        @(negedge ref_clk);
        modeRequestStrobe = 1'b0;
        modeRequest = `REQ_NONE;
    endtask : request
endmodule : mcu_model
`default_nettype wire

/* tb/testbench.sv */
/* self-checking bench of the mode controller.
   assumes the default cfg macros; fail-safe and thermal delays are not waited out. */
`timescale 1ns/100ps
`default_nettype none
`include "sbc_mode_cfg.svh"
module testbench;
    import sbc_mode_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic initAfterRelease, mainUv, mainOv, mainShort, thermalHot, watchdogFail;
    logic watchdogFailCountCfg, ovResetSelect, pullupConfig, measureSelect;
    logic auxSupplySel, gpioSwitchSel, statusClear, modeRequestStrobe, wakeStatusClear;
    logic mainSupplyOn, auxSupplyOn, reset_out_n, watchdogRun, watchdogLongWindow, spiEnable;
    logic gpioSwitchOn, cyclicEnable, failOutput, mainUvFlag, mainOvFlag, mainShortFlag;
    logic thermalFlag, failFlag, cmdFailFlag;
    logic [1:0] modeRequest, deviceStatus, watchdogFailCount;
    logic [2:0] watchdogPeriod;
    wake_t wakeEnable, wakeEvent, wakeSourceActive, wakeStatus;
    can_mode_t canModeSel, canMode;
    mode_e mode;
    int errors = 0;
    int checks_done = 0;
    sbc_lowpower_restart_failsafe_fsm sbc_lowpower_restart_failsafe_fsm_inst (.ref_clk, .rst,
        .modeRequest, .modeRequestStrobe, .initAfterRelease, .mainUv, .mainOv, .mainShort,
        .thermalHot, .watchdogFail, .watchdogFailCountCfg, .ovResetSelect, .pullupConfig,
        .measureSelect, .wakeEnable, .wakeEvent, .wakeStatusClear, .canModeSel, .auxSupplySel,
        .gpioSwitchSel, .statusClear, .mainSupplyOn, .auxSupplyOn, .reset_out_n, .watchdogRun,
        .watchdogLongWindow, .watchdogPeriod, .spiEnable, .gpioSwitchOn, .cyclicEnable,
        .canMode, .failOutput, .wakeSourceActive, .wakeStatus, .deviceStatus,
        .watchdogFailCount, .mainUvFlag, .mainOvFlag, .mainShortFlag, .thermalFlag,
        .failFlag, .cmdFailFlag, .mode);
    mcu_model mcu_model_inst (.ref_clk, .reset_out_n, .modeRequest, .modeRequestStrobe,
        .wakeStatusClear);
    always #25 ref_clk = ~ref_clk;
    // ****************
    // helpers
    // ****************
    task summarize;
        $display("errors=%0d checks=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    task chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            errors++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask : chk
    task waitMode(input mode_e m, input int n);
        for (int i = 0; i < n && mode !== m; i++) @(negedge ref_clk);
        chk(mode === m, "mode not reached");
        if (mode !== m) summarize();
    endtask : waitMode
    task doRst;
        rst = 1'b1;
        {initAfterRelease, mainUv, mainOv, mainShort, thermalHot, watchdogFail} = '0;
        {ovResetSelect, measureSelect, statusClear} = '0;
        {watchdogFailCountCfg, pullupConfig, auxSupplySel, gpioSwitchSel} = 4'hF;
        wakeEnable = 4'hF;
        wakeEvent = '0;
        canModeSel = `CAN_ON;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask : doRst
    task goNormal;
        mcu_model_inst.request(`REQ_NORMAL, 1'b0);
        waitMode(MODE_NORMAL, 6);
    endtask : goNormal
    task pulse(input int s);
        for (int v = 1; v >= 0; v--) begin
            case (s)
                0: mainUv = v[0];
                1: mainOv = v[0];
                2: watchdogFail = v[0];
                3: thermalHot = v[0];
                default: mainShort = v[0];
            endcase
            repeat (4) @(negedge ref_clk);
        end
    endtask : pulse
    // ****************
    // scenarios
    // ****************
    task t_sleep;
        doRst();
        canModeSel = `CAN_RXONLY;
        goNormal();
        mcu_model_inst.request(`REQ_SLEEP, 1'b0);
        waitMode(MODE_SLEEP, 6);
        chk(mainSupplyOn === 1'b0 && reset_out_n === 1'b0, "sleep supply");
        chk(canMode === `CAN_WAKE && auxSupplyOn === 1'b1, "sleep can or aux");
        chk(deviceStatus === `STAT_SLEEP, "sleep status");
        wakeEvent[`WAKE_PIN] = 1'b1;
        waitMode(MODE_RESTART, 6);
        chk(wakeStatus[`WAKE_PIN] === 1'b1 && auxSupplyOn === 1'b0, "wake record");
        waitMode(MODE_NORMAL, 300);
        chk(reset_out_n === 1'b1 && watchdogPeriod === `WD_PERIOD_DEFAULT, "exit");
        chk(watchdogLongWindow === 1'b1, "long window");
        chk(deviceStatus === `STAT_SLEEP, "wake cause");
    endtask : t_sleep
    task t_refuse;
        for (int k = 0; k < 4; k++) begin
            doRst();
            wakeEnable = (k == 0) ? 4'h0 : (k == 1) ? 4'h6 : 4'hF;
            measureSelect = (k == 1);
            goNormal();
            if (k == 2) mcu_model_inst.request(`REQ_STOP, 1'b0);
            if (k == 2) waitMode(MODE_STOP, 6);
            wakeEvent[`WAKE_BUS] = (k == 3);
            repeat (4) @(negedge ref_clk);
            mcu_model_inst.request(`REQ_SLEEP, k == 3);
            waitMode(MODE_RESTART, 8);
            chk(cmdFailFlag === (k != 3), "command fail flag");
        end
    endtask : t_refuse
    task t_event;
        int sg[9] = '{0, 1, 1, 1, 2, 2, 3, 4, 2};
        logic [0:8] ov = 9'h060;
        logic [0:8] pu = 9'h1D7;
        logic [0:8] cf = 9'h1FE;
        mode_e ex[9] = '{MODE_RESTART, MODE_NORMAL, MODE_RESTART, MODE_FAILSAFE, MODE_RESTART,
            MODE_FAILSAFE, MODE_FAILSAFE, MODE_FAILSAFE, MODE_RESTART};
        for (int i = 0; i < 9; i++) begin
            doRst();
            {ovResetSelect, pullupConfig, watchdogFailCountCfg} = {ov[i], pu[i], cf[i]};
            measureSelect = (sg[i] == 3);
            goNormal();
            pulse(sg[i]);
            chk(mode === ex[i], "event mode");
            case (sg[i])
                0: chk(mainUvFlag === 1'b1, "uv flag");
                1: chk(mainOvFlag === 1'b1 && failOutput === ov[i], "ov flag");
                2: chk(watchdogFailCount === `FAILCNT_ONE && failOutput === cf[i], "wd");
                3: chk(thermalFlag === 1'b1 && wakeSourceActive === 4'h1, "thermal");
                default: chk(mainShortFlag === 1'b1 && mainUvFlag === 1'b1, "short");
            endcase
            if (ex[i] === MODE_FAILSAFE) begin
                chk(failFlag === 1'b1 && deviceStatus === `STAT_FAIL, "fs status");
                chk(mainSupplyOn === 1'b0 && canMode === `CAN_WAKE, "fs");
                chk(wakeStatus === '0, "fs wake status");
            end
            if (ex[i] === MODE_RESTART) begin
                chk(reset_out_n === 1'b0 && gpioSwitchOn === 1'b0, "restart pins");
                waitMode(MODE_NORMAL, 300);
                chk(deviceStatus === `STAT_FAIL, "restart cause");
            end
        end
    endtask : t_event
    task t_second;
        for (int p = 0; p < 2; p++) begin
            doRst();
            {pullupConfig, watchdogFailCountCfg} = {p[0], 1'b0};
            goNormal();
            pulse(2);
            waitMode(MODE_NORMAL, 300);
            pulse(2);
            chk(mode === (p ? MODE_RESTART : MODE_FAILSAFE), "second failure");
            chk(watchdogFailCount === `FAILCNT_TWO && failOutput === 1'b1, "count");
        end
    endtask : t_second
    task t_clear;
        doRst();
        {initAfterRelease, canModeSel} = {1'b1, `CAN_OFF};
        pulse(0);
        chk(mode === MODE_RESTART && canMode === `CAN_OFF, "init uv");
        waitMode(MODE_NORMAL, 300);
        statusClear = 1'b1;
        @(negedge ref_clk);
        statusClear = 1'b0;
        chk(mainUvFlag === 1'b0 && deviceStatus === `STAT_NONE, "status clear");
        mcu_model_inst.request(`REQ_SLEEP, 1'b0);
        waitMode(MODE_SLEEP, 6);
        chk(canMode === `CAN_OFF, "sleep can off");
    endtask : t_clear
    initial begin
        t_sleep();
        t_refuse();
        t_event();
        t_second();
        t_clear();
        summarize();
    end
endmodule : testbench
`default_nettype wire
